// ---- rtl/usfu_core.sv ----
// User sequence function unit: eighteen programmable function blocks.
//
// Function
// - Codes 10-13 compare A,B; output C or 0.
// - Compare true with C zero outputs 1.
// - Code 14 loop timer counts completed loops.
// - Timer B=1 halts, output 0; B=0 runs.
// - Timer C=1 outputs count, else count>A flag.
// - Timer overflow restarts count at zero.
// - Code 15 limits A between C and B.
// - Codes 16-18 AND/OR/XOR; C zero ignored.
// - Code 19 (A AND B) OR C.
// - Code 20 selects B if A=1, C if 0.
// - Code 21 outputs bit B of A.
// - Bit index above 16 saturates; zero gives 0.
// - Codes 22/23 set or clear bit B.
// - Code 24 low-pass, time constant B loops.
// - Code 25 PI gains A/100, 1/B; error -1.
// - PI clamp mode C: const, 0..B, -B..B.
// - Code 26 error A, limit B, constant C.
// - Code 27 edge up-counter, B=1 holds 0.
// - Code 28 rising down-counter, B=1 loads C.
// - Codes 1-9 are the basic arithmetic set; code 0 outputs 0.
// - Eighteen blocks; outputs are read-only signed.
`include "usfu_defs.svh"
module usfu_core #(
    parameter int unsigned LOOP_CYCLES = `USFU_LOOP_CYCLES
) (
    input  wire logic        clk,       // 25 MHz system clock
    input  wire logic        reset_n,   // Asynchronous reset, active low
    input  wire logic [7:0]  addr,      // Register word address
    input  wire logic [15:0] wdata,     // Write data
    input  wire logic        wr,        // Write strobe
    input  wire logic        rd,        // Read strobe
    output logic      [15:0] rdata,     // Read data, valid the cycle after rd
    output logic             busy,      // Blocks are being evaluated
    output logic             loop_done  // One-cycle pulse after the last block
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
        if (v > `USFU_SAT_MAX) begin
            return 16'sh7FFF;
        end else if (v < `USFU_SAT_MIN) begin
            return -16'sh7FFF;
        end
        return v[15:0];
    endfunction

    function automatic logic signed [31:0] clamp32(input logic signed [31:0] v,
                                                   input logic signed [31:0] lo,
                                                   input logic signed [31:0] hi);
        if (v > hi) begin
            return hi;
        end else if (v < lo) begin
            return lo;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic signed [15:0] const_r [`USFU_NCONST];
    logic [4:0]         op_r    [`USFU_NBLK];
    logic [5:0]         src_r   [`USFU_NBLK][3];
    logic signed [15:0] out_r   [`USFU_NBLK];
    logic [15:0]        cnt_r   [`USFU_NBLK];
    logic               prev_r  [`USFU_NBLK];
    logic signed [31:0] acc_r   [`USFU_NBLK];
    logic               run_r;
    logic [31:0]        tick_cnt_r;
    logic               tick;
    usfu_pkg::usfu_state_t state_r;
    logic [4:0]         blk_r;
    logic [15:0]        loops_r;
    logic               pi_arm_r;
    logic signed [15:0] pi_kp_r;
    logic signed [15:0] pi_ti_r;
    logic [1:0]         pi_mode_r;

    // Source 0 reads as zero, which is how an unlinked C operand shows up.
    function automatic logic signed [15:0] fetch(input logic [5:0] sel);
        if (sel[`USFU_SRC_OUT_BIT]) begin
            return (sel[4:0] < 5'(`USFU_NBLK)) ? out_r[sel[4:0]] : 16'sh0000;
        end
        return (sel == 6'h00) ? 16'sh0000 : const_r[sel[4:0]];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Loop tick generator.
    assign tick = run_r && (tick_cnt_r == LOOP_CYCLES - 1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_r <= 32'h00000000;
        end else if (!run_r || tick) begin
            tick_cnt_r <= 32'h00000000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
        end
    end

    // One block per clock in ascending order after each tick.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= usfu_pkg::ST_IDLE;
            blk_r     <= 5'h00;
            busy      <= 1'b0;
            loop_done <= 1'b0;
            loops_r   <= 16'h0000;
        end else begin
            loop_done <= 1'b0;
            case (state_r)
                usfu_pkg::ST_IDLE: begin
                    if (tick) begin
                        state_r <= usfu_pkg::ST_EVAL;
                        blk_r   <= 5'h00;
                        busy    <= 1'b1;
                    end
                end
                usfu_pkg::ST_EVAL: begin
                    if (blk_r == 5'(`USFU_NBLK - 1)) begin
                        state_r   <= usfu_pkg::ST_IDLE;
                        busy      <= 1'b0;
                        loop_done <= 1'b1;
                        loops_r   <= loops_r + 16'h0001;
                    end else begin
                        blk_r <= blk_r + 5'h01;
                    end
                end
                default: begin
                    state_r <= usfu_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operand fetch and evaluation of the current block.
    logic signed [15:0] a, b, c, res, cnt_n;
    logic signed [31:0] acc_n;
    logic               arm_n, a_on, rise, fall, c_nil;
    logic signed [15:0] kp_n, ti_n;
    logic [1:0]         mode_n;
    logic [15:0]        bmask;
    logic signed [31:0] aw, bw, cw, lim, pt, it;

    always_comb begin
        a      = fetch(src_r[blk_r][0]);
        b      = fetch(src_r[blk_r][1]);
        c      = fetch(src_r[blk_r][2]);
        aw     = 32'(a);
        bw     = 32'(b);
        cw     = 32'(c);
        c_nil  = (c == 16'sh0000);
        a_on   = (a != 16'sh0000);
        rise   = a_on && !prev_r[blk_r];
        fall   = !a_on && prev_r[blk_r];
        res    = 16'sh0000;
        cnt_n  = cnt_r[blk_r];
        acc_n  = acc_r[blk_r];
        arm_n  = 1'b0;
        kp_n   = pi_kp_r;
        ti_n   = pi_ti_r;
        mode_n = pi_mode_r;
        lim    = (bw < 0) ? -bw : bw;
        pt     = 32'sh00000000;
        it     = 32'sh00000000;
        // Index 1..16 addresses bits 0..15; the result is unused when B <= 0.
        bmask  = (b > $signed(`USFU_BIT_MAX)) ? 16'h8000 : 16'h0001 << (b[4:0] - 5'h01);
        case (usfu_pkg::usfu_op_t'(op_r[blk_r]))
            usfu_pkg::OP_ADD:    res = sat16(aw + bw + cw);
            usfu_pkg::OP_SUB:    res = sat16(aw - bw - cw);
            usfu_pkg::OP_ADDSUB: res = sat16(aw + bw - cw);
            usfu_pkg::OP_MIN: begin
                res = (a < b) ? a : b;
                if (!c_nil && c < res) res = c;
            end
            usfu_pkg::OP_MAX: begin
                res = (a > b) ? a : b;
                if (!c_nil && c > res) res = c;
            end
            usfu_pkg::OP_ABS:    res = sat16((aw < 0) ? -aw : aw);
            usfu_pkg::OP_NEG:    res = sat16(-aw);
            usfu_pkg::OP_REM:    res = (b == 16'sh0000) ? 16'sh0000 : a % b;
            usfu_pkg::OP_MPYDIV: res = sat16(c_nil ? aw * bw : (aw * bw) / cw);
            usfu_pkg::OP_GT:     res = (a > b) ? (c_nil ? 16'sh0001 : c) : 16'sh0000;
            usfu_pkg::OP_GE:     res = (a >= b) ? (c_nil ? 16'sh0001 : c) : 16'sh0000;
            usfu_pkg::OP_EQ:     res = (a == b) ? (c_nil ? 16'sh0001 : c) : 16'sh0000;
            usfu_pkg::OP_NE:     res = (a != b) ? (c_nil ? 16'sh0001 : c) : 16'sh0000;
            usfu_pkg::OP_TIMER: begin
                if (b != 16'sh0001) begin
                    cnt_n = (cnt_r[blk_r] == `USFU_CNT_MAX) ? 16'h0000 : cnt_r[blk_r] + 16'h0001;
                    if (c == 16'sh0001) begin
                        res = cnt_n;
                    end else begin
                        res = (cnt_n > a) ? 16'sh0001 : 16'sh0000;
                    end
                end
            end
            usfu_pkg::OP_LIMIT:  res = (a > b) ? b : ((a < c) ? c : a);
            usfu_pkg::OP_AND:    res = c_nil ? (a & b) : (a & b & c);
            usfu_pkg::OP_OR:     res = c_nil ? (a | b) : (a | b | c);
            usfu_pkg::OP_XOR:    res = c_nil ? (a ^ b) : (a ^ b ^ c);
            usfu_pkg::OP_ANDOR:  res = (a & b) | c;
            usfu_pkg::OP_SWITCH: res = (a == 16'sh0001) ? b : ((a == 16'sh0000) ? c : 16'sh0000);
            usfu_pkg::OP_PROBE:  res = (b > 0 && (a & bmask) != 0) ? 16'sh0001 : 16'sh0000;
            usfu_pkg::OP_RAISE:  res = (b > 0) ? (a | bmask) : 16'sh0000;
            usfu_pkg::OP_DROP:   res = (b > 0) ? (a & ~bmask) : 16'sh0000;
            usfu_pkg::OP_SMOOTH: begin
                // Q8 state keeps small steps from stalling below one count.
                if (c_nil && b > 0) begin
                    acc_n = acc_r[blk_r] + ((aw <<< `USFU_FRAC) - acc_r[blk_r]) / bw;
                end else begin
                    acc_n = aw <<< `USFU_FRAC;
                end
                res = sat16(acc_n >>> `USFU_FRAC);
            end
            usfu_pkg::OP_PI_GAIN: begin
                if (a < 0 || b <= 0 || c < 0 || c > 16'sh0002) begin
                    res = -16'sh0001;
                end else begin
                    arm_n  = 1'b1;
                    kp_n   = a;
                    ti_n   = b;
                    mode_n = c[1:0];
                end
            end
            usfu_pkg::OP_PI_OUT: begin
                // Without a gain stage in the previous slot nothing runs.
                if (pi_arm_r) begin
                    pt = (aw * 32'(pi_kp_r)) / `USFU_PCT_DIV;
                    acc_n = acc_r[blk_r] + (aw <<< `USFU_FRAC) / 32'(pi_ti_r);
                    if (pi_mode_r == 2'd1) begin
                        acc_n = clamp32(acc_n, 32'sh0, lim <<< `USFU_FRAC);
                    end else if (pi_mode_r == 2'd2) begin
                        acc_n = clamp32(acc_n, -(lim <<< `USFU_FRAC), lim <<< `USFU_FRAC);
                    end
                    it = pt + (acc_n >>> `USFU_FRAC);
                    if (pi_mode_r == 2'd0) begin
                        res = sat16(clamp32(cw, 32'sh0, `USFU_SAT_MAX));
                    end else if (pi_mode_r == 2'd1) begin
                        res = sat16(clamp32(it, 32'sh0, lim));
                    end else begin
                        res = sat16(clamp32(it, -lim, lim));
                    end
                end
            end
            usfu_pkg::OP_UPCNT: begin
                if (b == 16'sh0001) begin
                    cnt_n = 16'h0000;
                end else if ((c == 16'sh0000 && rise) || (c == 16'sh0001 && fall) ||
                             (c == 16'sh0002 && (rise || fall))) begin
                    cnt_n = (cnt_r[blk_r] == `USFU_CNT_MAX) ? cnt_r[blk_r]
                                                             : cnt_r[blk_r] + 16'h0001;
                end
                res = cnt_n;
            end
            usfu_pkg::OP_DNCNT: begin
                if (b == 16'sh0001) begin
                    cnt_n = c;
                end else if (rise && cnt_r[blk_r] != 16'h0000) begin
                    cnt_n = cnt_r[blk_r] - 16'h0001;
                end
                res = cnt_n;
            end
            default: res = 16'sh0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-block state; outputs feed later blocks within the same loop.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `USFU_NBLK; i++) begin
                out_r[i]  <= 16'sh0000;
                cnt_r[i]  <= 16'h0000;
                prev_r[i] <= 1'b0;
                acc_r[i]  <= 32'sh00000000;
            end
            pi_arm_r  <= 1'b0;
            pi_kp_r   <= 16'sh0000;
            pi_ti_r   <= 16'sh0001;
            pi_mode_r <= 2'd0;
        end else if (state_r == usfu_pkg::ST_EVAL) begin
            out_r[blk_r]  <= res;
            cnt_r[blk_r]  <= cnt_n;
            prev_r[blk_r] <= a_on;
            acc_r[blk_r]  <= acc_n;
            pi_arm_r      <= arm_n;
            pi_kp_r       <= kp_n;
            pi_ti_r       <= ti_n;
            pi_mode_r     <= mode_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration writes; block outputs are not writable.
    logic [7:0] cfg_idx;
    assign cfg_idx = addr - `USFU_CFG_BASE;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `USFU_NCONST; i++) begin
                const_r[i] <= 16'sh0000;
            end
            for (int i = 0; i < `USFU_NBLK; i++) begin
                op_r[i]     <= 5'h00;
                src_r[i][0] <= 6'h00;
                src_r[i][1] <= 6'h00;
                src_r[i][2] <= 6'h00;
            end
            run_r <= `USFU_CTRL_RST;
        end else if (wr) begin
            if (addr < `USFU_CONST_END) begin
                const_r[addr[4:0]] <= wdata;
            end else if (addr >= `USFU_CFG_BASE && addr < `USFU_CFG_END) begin
                if (cfg_idx[1:0] == 2'd0) begin
                    op_r[cfg_idx[6:2]] <= wdata[4:0];
                end else begin
                    src_r[cfg_idx[6:2]][cfg_idx[1:0] - 2'd1] <= wdata[5:0];
                end
            end else if (addr == `USFU_CTRL_ADDR) begin
                run_r <= wdata[0];
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped words read zero.
    logic [7:0] out_idx;
    assign out_idx = addr - `USFU_OUT_BASE;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 16'h0000;
        end else if (!rd) begin
            rdata <= 16'h0000;
        end else if (addr < `USFU_CONST_END) begin
            rdata <= const_r[addr[4:0]];
        end else if (addr >= `USFU_CFG_BASE && addr < `USFU_CFG_END) begin
            rdata <= (cfg_idx[1:0] == 2'd0) ? {11'h000, op_r[cfg_idx[6:2]]}
                   : {10'h000, src_r[cfg_idx[6:2]][cfg_idx[1:0] - 2'd1]};
        end else if (addr >= `USFU_OUT_BASE && addr < `USFU_OUT_END) begin
            rdata <= out_r[out_idx[4:0]];
        end else if (addr == `USFU_CTRL_ADDR) begin
            rdata <= {15'h0000, run_r};
        end else if (addr == `USFU_STAT_ADDR) begin
            rdata <= loops_r;
        end else begin
            rdata <= 16'h0000;
        end
    end

endmodule

// ---- include/usfu_defs.svh ----
// Constants of the user sequence function unit: map, fields, limits and timing.
`ifndef USFU_DEFS_SVH
`define USFU_DEFS_SVH
`define USFU_NBLK        18
`define USFU_NCONST      32
`define USFU_CONST_END   8'h20
`define USFU_CFG_BASE    8'h40
`define USFU_CFG_END     8'h88
`define USFU_OUT_BASE    8'h90
`define USFU_OUT_END     8'hA2
`define USFU_CTRL_ADDR   8'hC0
`define USFU_STAT_ADDR   8'hC1
`define USFU_CTRL_RST    1'b0
`define USFU_SRC_OUT_BIT 5
`define USFU_SAT_MAX     32'sh00007FFF
`define USFU_SAT_MIN     -32'sh00007FFF
`define USFU_CNT_MAX     16'h7FFF
`define USFU_BIT_MAX     16'h0010
`define USFU_PCT_DIV     32'sh00000064
`define USFU_FRAC        8
`define USFU_LOOP_TIME_US 10000
`define USFU_CLK_MHZ     25
`define USFU_LOOP_CYCLES (`USFU_LOOP_TIME_US * `USFU_CLK_MHZ)
`endif

// ---- include/usfu_pkg.sv ----
// Types of the user sequence function unit.
package usfu_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EVAL = 2'b10
    } usfu_state_t;
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_ADDSUB = 5'h03,
        OP_MIN = 5'h04, OP_MAX = 5'h05, OP_ABS = 5'h06, OP_NEG = 5'h07,
        OP_REM = 5'h08, OP_MPYDIV = 5'h09, OP_GT = 5'h0A, OP_GE = 5'h0B,
        OP_EQ = 5'h0C, OP_NE = 5'h0D, OP_TIMER = 5'h0E, OP_LIMIT = 5'h0F,
        OP_AND = 5'h10, OP_OR = 5'h11, OP_XOR = 5'h12, OP_ANDOR = 5'h13,
        OP_SWITCH = 5'h14, OP_PROBE = 5'h15, OP_RAISE = 5'h16, OP_DROP = 5'h17,
        OP_SMOOTH = 5'h18, OP_PI_GAIN = 5'h19, OP_PI_OUT = 5'h1A,
        OP_UPCNT = 5'h1B, OP_DNCNT = 5'h1C
    } usfu_op_t;
endpackage

// ---- verification/usfu_properties.sv ----
// Assertion checker of the user sequence function unit, bound to its top module.
module usfu_properties #(
    parameter int unsigned LOOP_CYCLES = 40
) (
    input wire logic        clk,       // System clock
    input wire logic        reset_n,   // Asynchronous reset, active low
    input wire logic [7:0]  addr,      // Register word address
    input wire logic [15:0] wdata,     // Write data
    input wire logic        wr,        // Write strobe
    input wire logic        rd,        // Read strobe
    input wire logic [15:0] rdata,     // Read data
    input wire logic        busy,      // Evaluation in progress
    input wire logic        loop_done  // End of loop pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0]  busy_len;
    logic [15:0] idle_len;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_len <= 5'h00;
        end else if (busy) begin
            busy_len <= busy_len + 5'h01;
        end else begin
            busy_len <= 5'h00;
        end
    end
    // Idle length saturates so a long stop never wraps into a false short gap.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_len <= 16'hFFFF;
        end else if (busy) begin
            idle_len <= 16'h0000;
        end else if (idle_len != 16'hFFFF) begin
            idle_len <= idle_len + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    AST_BUSY_LEN: assert property ($fell(busy) |-> busy_len == 5'h12)
        else $error("busy did not last eighteen cycles");
    AST_BUSY_MAX: assert property (busy |-> busy_len < 5'h12)
        else $error("busy longer than eighteen cycles");
    AST_DONE_ON_FALL: assert property (loop_done |-> $fell(busy))
        else $error("loop_done without end of evaluation");
    AST_FALL_DONE: assert property ($fell(busy) |-> loop_done)
        else $error("evaluation ended without loop_done");
    AST_DONE_PULSE: assert property (loop_done |=> !loop_done)
        else $error("loop_done longer than one cycle");
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("rdata nonzero outside read answer");
    AST_UNMAPPED: assert property ($past(rd) && $past(addr) >= 8'h20 && $past(addr) < 8'h40
        |-> rdata == 16'h0000)
        else $error("unmapped read gave nonzero data");
    AST_LOOP_GAP: assert property ($rose(busy) |-> idle_len >= LOOP_CYCLES - 20)
        else $error("loops evaluated too close together");
    COV_LOOP: cover property ($fell(busy));
    COV_STAT: cover property ($past(rd) && $past(addr) == 8'hC1);
    COV_RUN: cover property ($past(wr) && $past(addr) == 8'hC0 && $past(wdata) == 16'h0001);
endmodule
bind usfu_core usfu_properties #(.LOOP_CYCLES(LOOP_CYCLES)) i_usfu_properties (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .busy(busy), .loop_done(loop_done));

// ---- verification/testbench.sv ----
// Self-checking testbench of the user sequence function unit.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        reset_n;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        busy;
    logic        loop_done;
    logic [15:0] k [32];
    int          fails;
    int          compares;
    logic [15:0] warm [18] = '{16'h0001, 0, 0, 0, 0, 0, 16'h000A, 16'hFFFF, 0, 16'h0064, 16'h0064,
                               0, 16'h0096, 16'h0032, 0, 16'hFFF9, 16'h0136, 16'h7FFF};
    logic [15:0] last [18] = '{16'h0006, 16'h0001, 0, 16'h0003, 16'h0002, 16'h0005, 16'h0007,
                               16'hFFFF, 0, 16'h0064, 16'h0064, 0, 16'h00C8, 16'h0062, 0,
                               16'hFFF6, 16'h0136, 16'h7FFF};

    usfu_core #(.LOOP_CYCLES(40)) i_dut (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .busy(busy), .loop_done(loop_done));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // The answer stands only in the cycle after the strobe, so it is taken just after that edge.
    task automatic rd_check(input logic [7:0] a, input logic [15:0] e, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(what, rdata, e);
    endtask
    task automatic set_k(input int i, input logic [15:0] v);
        k[i] = v;
        wr_reg(8'(i), v);
    endtask
    task automatic cfg(input int n, input int op, input int a, input int b, input int c);
        wr_reg(8'(8'h40 + 4 * n), 16'(op));
        wr_reg(8'(8'h41 + 4 * n), 16'(a));
        wr_reg(8'(8'h42 + 4 * n), 16'(b));
        wr_reg(8'(8'h43 + 4 * n), 16'(c));
    endtask
    task automatic run_loop();
        int i;
        wr_reg(8'hC0, 16'h0001);
        i = 0;
        while (loop_done !== 1'b1 && i < 200) begin
            @(posedge clk);
            #1;
            i++;
        end
        if (i >= 200) begin
            fails++;
            give_verdict();
        end
        wr_reg(8'hC0, 16'h0000);
    endtask
    function automatic logic [15:0] expect_op(input int op, input logic signed [15:0] a,
                                              input logic signed [15:0] b,
                                              input logic signed [15:0] c);
        logic signed [15:0] r;
        int                 bi;
        logic               hit;
        bi = (b > 16) ? 16 : int'(b);
        hit = (op == 10 && a > b) || (op == 11 && a >= b) || (op == 12 && a == b)
            || (op == 13 && a != b);
        r = 16'sh0000;
        case (op)
            10, 11, 12, 13: r = !hit ? 16'sh0000 : (c == 0) ? 16'sh0001 : c;
            15: r = (a > b) ? b : (a < c) ? c : a;
            16: r = (c == 0) ? (a & b) : (a & b & c);
            17: r = a | b | c;
            18: r = a ^ b ^ c;
            19: r = (a & b) | c;
            20: r = (a == 1) ? b : (a == 0) ? c : 16'sh0000;
            21: r = (bi <= 0) ? 16'sh0000 : 16'(a[bi - 1]);
            22: r = (bi <= 0) ? 16'sh0000 : a | (16'sh0001 << (bi - 1));
            23: r = (bi <= 0) ? 16'sh0000 : a & ~(16'sh0001 << (bi - 1));
            default: r = 16'sh0000;
        endcase
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int          t;
        int          n;
        int          op [18];
        int          sa [18];
        int          sb [18];
        int          sc [18];
        logic [15:0] v;
        reset_n = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        fails = 0;
        compares = 0;
        for (n = 0; n < 32; n++) begin
            k[n] = 16'h0000;
        end
        void'($urandom(42637));
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd_check(8'hC1, 16'h0000, "loop count after reset");
        for (t = 0; t < 3; t++) begin
            for (n = 1; n < 32; n++) begin
                v = (n < 11) ? 16'($urandom_range(20)) : 16'($urandom);
                v = (v == 16'h8000) ? 16'h7FFF : v;
                v = (n == 1) ? 16'h0001 : (n == 2) ? 16'h0000 : (n == 3) ? 16'h0011 : v;
                set_k(n, (n == 4) ? 16'h0010 : v);
            end
            for (n = 0; n < 18; n++) begin
                op[n] = (t == 0 && n < 4) ? 10 + n : $urandom_range(23, 10);
                op[n] = (op[n] == 14) ? 20 : op[n];
                sa[n] = (op[n] == 20) ? $urandom_range(2, 1) : $urandom_range(31, 1);
                sb[n] = (op[n] > 20) ? $urandom_range(10, 3) : $urandom_range(31, 1);
                sc[n] = (t == 0 && n < 4) ? 0 : $urandom_range(31, 0);
                sb[n] = (t == 0 && n < 4) ? sa[n] : sb[n];
                if (op[n] == 15 && $signed(k[sb[n]]) < $signed(k[sc[n]])) begin
                    v = 16'(sb[n]);
                    sb[n] = sc[n];
                    sc[n] = int'(v);
                end
                cfg(n, op[n], sa[n], sb[n], sc[n]);
            end
            run_loop();
            for (n = 0; n < 18; n++) begin
                v = expect_op(op[n], k[sa[n]], k[sb[n]], k[sc[n]]);
                if (v !== 16'h8000) begin
                    rd_check(8'(8'h90 + n), v, "block output");
                end
            end
        end
        rd_check(8'h05, k[5], "constant readback");
        rd_check(8'h30, 16'h0000, "unmapped read");
        wr_reg(8'h90, 16'h1234);
        rd_check(8'h90, expect_op(op[0], k[sa[0]], k[sb[0]], k[sc[0]]), "read-only output");
        rd_check(8'hC1, 16'h0003, "loop count");
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_check(8'h90, 16'h0000, "output after reset");
        set_k(1, 16'h0001);
        set_k(2, 16'h0000);
        set_k(3, 16'h0002);
        set_k(20, 16'h0000);
        set_k(21, 16'h0001);
        set_k(22, 16'h000A);
        set_k(23, 16'hFFFB);
        set_k(24, 16'h0032);
        set_k(25, 16'h00C8);
        set_k(26, 16'h0064);
        cfg(0, 14, 3, 2, 1);
        cfg(1, 14, 3, 2, 2);
        cfg(2, 14, 3, 1, 1);
        cfg(3, 27, 20, 21, 2);
        cfg(4, 27, 20, 21, 1);
        cfg(5, 27, 20, 21, 3);
        cfg(6, 28, 20, 21, 22);
        cfg(7, 25, 23, 1, 0);
        cfg(8, 25, 24, 1, 0);
        cfg(9, 26, 2, 25, 26);
        cfg(10, 24, 26, 1, 0);
        cfg(11, 25, 24, 1, 1);
        cfg(12, 26, 26, 25, 26);
        cfg(13, 24, 41, 3, 0);
        cfg(14, 25, 24, 1, 3);
        cfg(15, 26, 23, 22, 22);
        cfg(16, 1, 25, 26, 22);
        cfg(17, 9, 25, 25, 1);
        run_loop();
        for (n = 0; n < 18; n++) begin
            rd_check(8'(8'h90 + n), warm[n], "held block");
        end
        set_k(21, 16'h0000);
        for (t = 0; t < 5; t++) begin
            set_k(20, (t % 2 == 0) ? 16'h0001 : 16'h0000);
            run_loop();
        end
        for (n = 0; n < 18; n++) begin
            rd_check(8'(8'h90 + n), last[n], "running block");
        end
        rd_check(8'hC1, 16'h0006, "loop count");
        give_verdict();
    end
endmodule
